// [include/cspc_pkg.sv]
package cspc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Least extra wait after the init line rises in master modes
  localparam int unsigned MASTER_WAIT_NS = 30000;
  localparam int unsigned MASTER_WAIT_CYC =
    (MASTER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 16;

  // Power stabilisation, memory clear and master extra wait lengths in clock cycles
  localparam logic [CNT_W-1:0] PWR_CYC_DEF = 16'h0040;
  localparam logic [CNT_W-1:0] CLR_CYC_DEF = 16'h0100;
  localparam logic [CNT_W-1:0] MWAIT_CYC_DEF = CNT_W'(MASTER_WAIT_CYC);

  localparam int unsigned SYNC_W = 2;
  localparam int unsigned SYNC_INIT_BIT = 0;
  localparam int unsigned SYNC_MODE_BIT = 1;

  typedef enum logic [2:0] {
    ST_POWER,
    ST_CLEAR,
    ST_WAIT,
    ST_DELAY,
    ST_CONFIG,
    ST_ERROR,
    ST_DONE
  } cspc_state_t;

endpackage

// [hdl/cspc_sync.sv]
`timescale 1ns/1ns
module cspc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Reset high: an idle open-drain line sits pulled up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// [hdl/cspc_top.sv]
`timescale 1ns/1ns
module cspc_top #(
  parameter logic [15:0] PWR_CYC   = cspc_pkg::PWR_CYC_DEF,
  parameter logic [15:0] CLR_CYC   = cspc_pkg::CLR_CYC_DEF,
  parameter logic [15:0] MWAIT_CYC = cspc_pkg::MWAIT_CYC_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic init_i,
  input  wire logic master_mode_i,
  input  wire logic cfg_data_error,
  input  wire logic cfg_done,
  input  wire logic scan_enable_primitive,
  input  wire logic user_high_o,
  input  wire logic user_high_oe,
  input  wire logic user_low_o,
  input  wire logic user_low_oe,
  input  wire logic user_init_o,
  input  wire logic user_init_oe,
  output logic      configuring_high_flag_o,
  output logic      configuring_high_flag_oe,
  output logic      configuring_low_flag_o,
  output logic      configuring_low_flag_oe,
  output logic      init_o,
  output logic      init_oe,
  output logic      init_level,
  output logic      cfg_start,
  output logic      cfg_error,
  output logic      io_active,
  output logic      scan_active,
  output logic      test_pins_user
);

  logic [cspc_pkg::SYNC_W-1:0] pins_sync;
  logic                        init_s;
  logic                        master_s;

  cspc_sync #(
    .W (cspc_pkg::SYNC_W)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({master_mode_i, init_i}),
    .sync_out (pins_sync)
  );

  assign init_s   = pins_sync[cspc_pkg::SYNC_INIT_BIT];
  assign master_s = pins_sync[cspc_pkg::SYNC_MODE_BIT];

  // Sequence state
  cspc_pkg::cspc_state_t state_reg;
  cspc_pkg::cspc_state_t state_next;
  logic [15:0]           cnt_reg;
  logic [15:0]           cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 16'h0001;
    case (state_reg)
      cspc_pkg::ST_POWER: begin
        if (cnt_reg == PWR_CYC - 16'h0001) begin
          state_next = cspc_pkg::ST_CLEAR;
          cnt_next   = 16'h0000;
        end
      end
      cspc_pkg::ST_CLEAR: begin
        if (cnt_reg == CLR_CYC - 16'h0001) begin
          state_next = cspc_pkg::ST_WAIT;
          cnt_next   = 16'h0000;
        end
      end
      cspc_pkg::ST_WAIT: begin
        cnt_next = 16'h0000;
        if (init_s) begin
          state_next = master_s ? cspc_pkg::ST_DELAY : cspc_pkg::ST_CONFIG;
        end
      end
      cspc_pkg::ST_DELAY: begin
        if (cnt_reg == MWAIT_CYC - 16'h0001) begin
          state_next = cspc_pkg::ST_CONFIG;
          cnt_next   = 16'h0000;
        end
      end
      cspc_pkg::ST_CONFIG: begin
        cnt_next = 16'h0000;
        if (cfg_data_error) begin
          state_next = cspc_pkg::ST_ERROR;
        end else if (cfg_done) begin
          state_next = cspc_pkg::ST_DONE;
        end
      end
      // Only a reset leaves a failed load; the data cannot be trusted
      cspc_pkg::ST_ERROR: begin
        cnt_next = 16'h0000;
      end
      cspc_pkg::ST_DONE: begin
        cnt_next = 16'h0000;
      end
      default: begin
        state_next = cspc_pkg::ST_POWER;
        cnt_next   = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cspc_pkg::ST_POWER;
      cnt_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Pin state, all but init_level computed from the next sequence state so that pins
  // and state flags change on the same edge
  logic hi_o_reg, hi_o_next, hi_oe_reg, hi_oe_next;
  logic lo_o_reg, lo_o_next, lo_oe_reg, lo_oe_next;
  logic in_o_reg, in_o_next, in_oe_reg, in_oe_next;
  logic act_reg, act_next, start_reg, start_next;
  logic err_reg, err_next, scan_reg, scan_next;
  logic tpu_reg, tpu_next, lvl_reg, lvl_next;

  always_comb begin
    act_next   = (state_next == cspc_pkg::ST_DONE);
    err_next   = (state_next == cspc_pkg::ST_ERROR);
    start_next = (state_next == cspc_pkg::ST_CONFIG) &&
                 (state_reg != cspc_pkg::ST_CONFIG);
    lvl_next   = init_s;
    if (act_next) begin
      hi_o_next  = user_high_o;
      hi_oe_next = user_high_oe;
      lo_o_next  = user_low_o;
      lo_oe_next = user_low_oe;
      in_o_next  = user_init_o;
      in_oe_next = user_init_oe;
    end else begin
      hi_o_next  = 1'b1;
      hi_oe_next = 1'b1;
      lo_o_next  = 1'b0;
      lo_oe_next = 1'b1;
      in_o_next  = 1'b0;
      in_oe_next = (state_next == cspc_pkg::ST_POWER) ||
                   (state_next == cspc_pkg::ST_CLEAR) || err_next;
    end
    scan_next = !act_next || scan_enable_primitive;
    tpu_next  = act_next && !scan_enable_primitive;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_o_reg  <= 1'b1;
      hi_oe_reg <= 1'b1;
      lo_o_reg  <= 1'b0;
      lo_oe_reg <= 1'b1;
      in_o_reg  <= 1'b0;
      in_oe_reg <= 1'b1;
      act_reg   <= 1'b0;
      start_reg <= 1'b0;
      err_reg   <= 1'b0;
      scan_reg  <= 1'b1;
      tpu_reg   <= 1'b0;
      lvl_reg   <= 1'b1;
    end else begin
      hi_o_reg  <= hi_o_next;
      hi_oe_reg <= hi_oe_next;
      lo_o_reg  <= lo_o_next;
      lo_oe_reg <= lo_oe_next;
      in_o_reg  <= in_o_next;
      in_oe_reg <= in_oe_next;
      act_reg   <= act_next;
      start_reg <= start_next;
      err_reg   <= err_next;
      scan_reg  <= scan_next;
      tpu_reg   <= tpu_next;
      lvl_reg   <= lvl_next;
    end
  end

  assign configuring_high_flag_o  = hi_o_reg;
  assign configuring_high_flag_oe = hi_oe_reg;
  assign configuring_low_flag_o   = lo_o_reg;
  assign configuring_low_flag_oe  = lo_oe_reg;
  assign init_o                   = in_o_reg;
  assign init_oe                  = in_oe_reg;
  assign init_level               = lvl_reg;
  assign cfg_start                = start_reg;
  assign cfg_error                = err_reg;
  assign io_active                = act_reg;
  assign scan_active              = scan_reg;
  assign test_pins_user           = tpu_reg;

  // Checks
  sequence seq_wait_low;
    state_reg == cspc_pkg::ST_WAIT && !init_s;
  endsequence

  sequence seq_master_release;
    state_reg == cspc_pkg::ST_WAIT && init_s && master_s;
  endsequence

  AST_HIGH_FLAG: assert property (
    @(posedge clk) disable iff (!rst_n)
    !io_active |-> (configuring_high_flag_o && configuring_high_flag_oe))
    else $error("High configuring flag not driven high");

  AST_LOW_FLAG: assert property (
    @(posedge clk) disable iff (!rst_n)
    !io_active |-> (!configuring_low_flag_o && configuring_low_flag_oe))
    else $error("Low configuring flag not driven low");

  AST_HANDOVER: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_active |-> (init_oe == $past(user_init_oe) &&
                   configuring_high_flag_o == $past(user_high_o) &&
                   configuring_low_flag_oe == $past(user_low_oe)))
    else $error("Pins not handed to user logic");

  AST_CLEAR_PULL: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cspc_pkg::ST_POWER || state_reg == cspc_pkg::ST_CLEAR)
      |-> (init_oe && !init_o))
    else $error("Init line not pulled low while clearing");

  AST_WAIT_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_wait_low |=> (state_reg == cspc_pkg::ST_WAIT && !cfg_start))
    else $error("Left wait state while init held low");

  AST_MASTER_DELAY: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_master_release |=> (state_reg == cspc_pkg::ST_DELAY)
      ##1 (state_reg == cspc_pkg::ST_DELAY)[*8])
    else $error("Master mode skipped extra wait");

  AST_DELAY_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cspc_pkg::ST_CONFIG &&
     $past(state_reg) == cspc_pkg::ST_DELAY)
      |-> ($past(cnt_reg) == MWAIT_CYC - 16'h0001))
    else $error("Master extra wait has wrong length");

  AST_DATA_ERROR: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cspc_pkg::ST_CONFIG && cfg_data_error)
      |=> (init_oe && !init_o && cfg_error)[*3])
    else $error("Data error not shown on init line");

  AST_SCAN_OFF: assert property (
    @(posedge clk) disable iff (!rst_n)
    (io_active && !$past(scan_enable_primitive))
      |-> (test_pins_user && !scan_active))
    else $error("Scan not disabled without primitive");

  AST_RELEASE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cspc_pkg::ST_WAIT || state_reg == cspc_pkg::ST_DELAY ||
     state_reg == cspc_pkg::ST_CONFIG) |-> !init_oe)
    else $error("Init line not released after clearing");

endmodule

// [tb/cspc_host_model.sv]
`timescale 1ns/1ns
module cspc_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold_low,
  input  wire logic dev_o,
  input  wire logic dev_oe,
  output logic      init_wire,
  output logic      data_go
);
  // host holds line
  // Pull-up wins unless some party pulls the line low
  assign init_wire = ((dev_oe & ~dev_o) | hold_low) ? 1'b0 : 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_go <= 1'b0;
    end else begin
      data_go <= init_wire;
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  localparam logic [15:0] PWR = 16'h0004;
  localparam logic [15:0] CLR = 16'h0008;
  localparam logic [15:0] MW  = 16'h000a;
  logic clk, rst_n, hold_low, master, err, done, keep;
  logic uh_o, uh_oe, ul_o, ul_oe, ui_o, ui_oe;
  logic hf_o, hf_oe, lf_o, lf_oe, in_o, in_oe, in_lvl;
  logic start, c_err, io_act, scan_act, tp_user, init_wire, data_go;
  int   mismatches, n_compared, n;

  cspc_top #(.PWR_CYC(PWR), .CLR_CYC(CLR), .MWAIT_CYC(MW)) i_dut (
    .clk(clk), .rst_n(rst_n), .init_i(init_wire),
    .master_mode_i(master), .cfg_data_error(err), .cfg_done(done),
    .scan_enable_primitive(keep), .user_high_o(uh_o),
    .user_high_oe(uh_oe), .user_low_o(ul_o), .user_low_oe(ul_oe),
    .user_init_o(ui_o), .user_init_oe(ui_oe),
    .configuring_high_flag_o(hf_o), .configuring_high_flag_oe(hf_oe),
    .configuring_low_flag_o(lf_o), .configuring_low_flag_oe(lf_oe),
    .init_o(in_o), .init_oe(in_oe), .init_level(in_lvl),
    .cfg_start(start), .cfg_error(c_err), .io_active(io_act),
    .scan_active(scan_act), .test_pins_user(tp_user));

  cspc_host_model i_host (
    .clk(clk), .rst_n(rst_n), .hold_low(hold_low), .dev_o(in_o),
    .dev_oe(in_oe), .init_wire(init_wire), .data_go(data_go));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Counts cycles spent with the device pulling, flags checked each cycle
  task automatic wait_clear(output int cnt);
    cnt = 0;
    forever begin
      @(negedge clk);
      if (in_oe !== 1'b1) break;
      cnt++;
      check("high_flag", 1'b1, hf_o & hf_oe);
      check("low_flag", 1'b0, lf_o | ~lf_oe);
      if (cnt > 300) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask

  task automatic wait_start(input int bound, output int cnt);
    cnt = 0;
    while (start !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > bound) begin
        mismatches++;
        give_verdict();
      end
    end
  endtask

  // Done pulse for one cycle, result on the same edge that samples it
  task automatic pulse_done();
    @(posedge clk);
    done <= 1'b1;
    @(negedge clk);
    check("io_before", 1'b0, io_act);
    check("start_pulse", 1'b0, start);
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_power_clear();
    reset_dut();
    wait_clear(n);
    check("clear_len", 1'b1, n == int'(PWR + CLR));
    check("init_release", 1'b0, in_oe);
    check("wire_high", 1'b1, init_wire);
    check("level_low", 1'b0, in_lvl);
    // Two sync stages plus the level register
    repeat (3) @(negedge clk);
    check("level_high", 1'b1, in_lvl);
  endtask

  task automatic t_hold_slave();
    @(posedge clk);
    hold_low <= 1'b1;
    reset_dut();
    wait_clear(n);
    repeat (40) begin
      @(negedge clk);
      check("no_start", 1'b0, start);
      check("level_held", 1'b0, in_lvl);
      check("data_wait", 1'b0, data_go);
    end
    @(posedge clk);
    hold_low <= 1'b0;
    wait_start(8, n);
    check("data_go", 1'b1, data_go);
    pulse_done();
    check("io_active", 1'b1, io_act);
    check("hf_user", 1'b0, hf_o);
    check("hf_oe_user", 1'b0, hf_oe);
    check("lf_user", 1'b1, lf_o);
    check("lf_oe_user", 1'b0, lf_oe);
    check("init_user", 1'b1, in_o & in_oe);
    check("scan_off", 1'b0, scan_act);
    check("pins_user", 1'b1, tp_user);
  endtask

  task automatic t_master_error();
    @(posedge clk);
    master <= 1'b1;
    reset_dut();
    wait_clear(n);
    wait_start(int'(MW) + 8, n);
    check("master_wait", 1'b1, n >= int'(MW));
    @(posedge clk);
    err  <= 1'b1;
    done <= 1'b1;
    @(posedge clk);
    err  <= 1'b0;
    done <= 1'b0;
    @(negedge clk);
    check("cfg_error", 1'b1, c_err);
    check("err_pull", 1'b0, init_wire);
    check("no_io", 1'b0, io_act);
    check("hf_held", 1'b1, hf_o);
  endtask

  task automatic t_scan_keep();
    @(posedge clk);
    master <= 1'b0;
    keep   <= 1'b1;
    reset_dut();
    wait_clear(n);
    wait_start(8, n);
    pulse_done();
    check("scan_kept", 1'b1, scan_act);
    check("pins_test", 1'b0, tp_user);
  endtask

  initial begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {hold_low, master, err, done, keep} = 5'h00;
    // User values differ from the configuring levels on the flag pins
    {uh_o, uh_oe, ul_o, ul_oe, ui_o, ui_oe} = 6'h0b;
    repeat (2) @(posedge clk);
    t_power_clear();
    t_hold_slave();
    t_master_error();
    t_scan_keep();
    give_verdict();
  end
endmodule
